//--- shared/dmcl_pkg.sv
/*
 Constants for the display-mode command logic: command codes, gamma
 curve encodings and reset defaults.
 Assumes a command front end that delivers decoded words on the core clock.
*/
package dmcl_pkg;
   localparam logic [7:0] DMCL_CMD_PARTIAL_ON = 8'h12;
   localparam logic [7:0] DMCL_CMD_NORMAL = 8'h13;
   localparam logic [7:0] DMCL_CMD_INV_OFF = 8'h20;
   localparam logic [7:0] DMCL_CMD_INV_ON = 8'h21;
   localparam logic [7:0] DMCL_CMD_ALL_BLACK = 8'h22;
   localparam logic [7:0] DMCL_CMD_ALL_WHITE = 8'h23;
   localparam logic [7:0] DMCL_CMD_GAMMA = 8'h26;
   localparam logic [7:0] DMCL_CMD_DISP_OFF = 8'h28;
   localparam logic [7:0] DMCL_CMD_DISP_ON = 8'h29;
   localparam logic [7:0] DMCL_LONG_LOW = 8'h00;
   localparam logic [15:0] DMCL_FILLER = 16'h0000;
   localparam logic [7:0] DMCL_GAMMA_CURVE1 = 8'h01;
   localparam logic [7:0] DMCL_GAMMA_RSV2 = 8'h02;
   localparam logic [7:0] DMCL_GAMMA_RSV3 = 8'h04;
   localparam logic [7:0] DMCL_GAMMA_RSV4 = 8'h08;
   localparam logic [7:0] DMCL_GAMMA_RESET = 8'h01;
   localparam logic DMCL_PARTIAL_RESET = 1'b0;
   localparam logic DMCL_INV_RESET = 1'b0;
   localparam logic DMCL_DISP_ON_RESET = 1'b0;

   typedef enum logic [2:0] {
      DMCL_PIX_FRAME = 3'b001,
      DMCL_PIX_BLACK = 3'b010,
      DMCL_PIX_WHITE = 3'b100
   } dmcl_pix_e;
   localparam dmcl_pix_e DMCL_PIX_RESET = DMCL_PIX_FRAME;
endpackage : dmcl_pkg

//--- verilog/dmcl_cmd_decode.sv
/*
 Command word decoder: folds the 8-bit short form and 16-bit long form
 into one command code and flags the gamma parameter word.
 Assumes words arrive as single-cycle strobes on the core clock.
*/
`timescale 1ns/1ps
module dmcl_cmd_decode
   import dmcl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_long_i,
   input wire logic [15:0] cmd_word_i,
   input wire logic param_valid_i,
   input wire logic [15:0] param_word_i,
   output logic cmd_stb_o,
   output logic [7:0] cmd_code_o,
   output logic gamma_stb_o,
   output logic [7:0] gamma_val_o
);
   logic pend_gamma;
   logic [7:0] code_in;
   logic code_ok;
   logic cmd_take;
   logic gamma_take;

   // Long form puts the code in the upper byte, low byte must be zero
   assign code_in = cmd_long_i ? cmd_word_i[15:8] : cmd_word_i[7:0];
   assign code_ok = cmd_long_i ? (cmd_word_i[7:0] == DMCL_LONG_LOW)
                               : (cmd_word_i[15:8] == 8'h00);
   assign cmd_take = cmd_valid_i && code_ok;
   // A filler word after an argument-free command is simply not consumed
   assign gamma_take = param_valid_i && pend_gamma && !cmd_valid_i;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pend_gamma <= 1'b0;
         cmd_stb_o <= 1'b0;
         cmd_code_o <= 8'h00;
         gamma_stb_o <= 1'b0;
         gamma_val_o <= 8'h00;
      end
      else
      begin
         cmd_stb_o <= cmd_take;
         gamma_stb_o <= gamma_take;
         if (cmd_take)
         begin
            cmd_code_o <= code_in;
            pend_gamma <= (code_in == DMCL_CMD_GAMMA);
         end
         else if (gamma_take)
         begin
            pend_gamma <= 1'b0;
         end
         if (gamma_take)
         begin
            gamma_val_o <= param_word_i[7:0];
         end
      end
   end
endmodule : dmcl_cmd_decode

//--- verilog/dmcl_mode_ctrl.sv
/*
 Display-mode command logic: holds partial/normal mode, inversion,
 forced all-black/all-white, gamma curve and display on/off.
 Assumes the command front end delivers one word per strobe on clk_i and
 that sw_reset_i is a one-cycle pulse from the software-reset decoder.
*/
//Contract
//- Normal-display command (13h / 1300h) leaves partial mode.
//- Normal-display command while normal is a no-operation.
//- Only partial-on (12h) leaves normal mode; switching shows no glitch.
//- Power-on, software and hardware reset select normal mode.
//- Argument-free commands take no parameter; a 0000h filler is accepted.
//- Inversion-on (21h / 2100h) enables inversion; off after any reset.
//- Inversion-on while already inverted is ignored.
//- All-black (22h) blanks panel in sleep-out, regardless of display on/off.
//- Forced pixel modes keep frame memory and other status unchanged.
//- Normal or partial-on ends forced modes; all-black ends all-white.
//- All-white (23h) whitens panel in sleep-out, regardless of on/off.
//- All-white while already all-white is ignored.
//- Any reset returns forced-pixel state to its frame-display default (DMCL_PIX_FRAME).
//- Gamma command 26h takes one one-hot byte; 01h is curve 1, default.
//- Undefined gamma values keep the current curve.
//- Display-off (28h) blanks output, keeps status; it is the reset default.
//- Display-off while already off is a no-operation.
//- All commands act in every normal/partial, idle and sleep combination.
//- Display-on (29h) re-enables frame output; ignored when already on.
`timescale 1ns/1ps
module dmcl_mode_ctrl
   import dmcl_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic sw_reset_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_long_i,
   input wire logic [15:0] cmd_word_i,
   input wire logic param_valid_i,
   input wire logic [15:0] param_word_i,
   input wire logic sleep_out_i,
   output logic partial_mode_o,
   output logic inversion_o,
   output logic all_black_o,
   output logic all_white_o,
   output logic [7:0] gamma_curve_select_o,
   output logic display_on_o,
   output logic panel_blank_o,
   output logic panel_black_o,
   output logic panel_white_o,
   output logic panel_invert_o,
   output logic mode_change_o
);
   import dmcl_pkg::*;

   logic rst_meta;
   logic rst_sync;
   logic cmd_stb;
   logic [7:0] cmd_code;
   logic gamma_stb;
   logic [7:0] gamma_val;
   logic partial;
   logic inversion;
   dmcl_pix_e pix;
   logic [7:0] gamma_curve;
   logic disp_on;
   logic next_partial;
   logic next_inversion;
   dmcl_pix_e next_pix;
   logic [7:0] next_gamma;
   logic next_disp_on;
   logic is_normal;
   logic is_partial;
   logic is_inv_on;
   logic is_inv_off;
   logic is_black;
   logic is_white;
   logic is_disp_off;
   logic is_disp_on;
   logic gamma_ok;
   logic any_change;

   // Reset release is synchronised so every mode flop leaves reset together
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   dmcl_cmd_decode u_decode (
      .clk_i(clk_i),
      .rst_n_i(rst_sync),
      .cmd_valid_i(cmd_valid_i),
      .cmd_long_i(cmd_long_i),
      .cmd_word_i(cmd_word_i),
      .param_valid_i(param_valid_i),
      .param_word_i(param_word_i),
      .cmd_stb_o(cmd_stb),
      .cmd_code_o(cmd_code),
      .gamma_stb_o(gamma_stb),
      .gamma_val_o(gamma_val)
   );

   // Decoding carries no gate on sleep or idle state
   assign is_normal = cmd_stb && (cmd_code == DMCL_CMD_NORMAL);
   assign is_partial = cmd_stb && (cmd_code == DMCL_CMD_PARTIAL_ON);
   assign is_inv_on = cmd_stb && (cmd_code == DMCL_CMD_INV_ON);
   assign is_inv_off = cmd_stb && (cmd_code == DMCL_CMD_INV_OFF);
   assign is_black = cmd_stb && (cmd_code == DMCL_CMD_ALL_BLACK);
   assign is_white = cmd_stb && (cmd_code == DMCL_CMD_ALL_WHITE);
   assign is_disp_off = cmd_stb && (cmd_code == DMCL_CMD_DISP_OFF);
   assign is_disp_on = cmd_stb && (cmd_code == DMCL_CMD_DISP_ON);

   // Reserved one-hot codes are accepted as a selection but not undefined ones
   assign gamma_ok = (gamma_val == DMCL_GAMMA_CURVE1) || (gamma_val == DMCL_GAMMA_RSV2)
                     || (gamma_val == DMCL_GAMMA_RSV3) || (gamma_val == DMCL_GAMMA_RSV4);

   // Setting an already active mode rewrites the same value: no visible effect
   assign next_partial = is_partial ? 1'b1
                       : is_normal ? 1'b0
                       : partial;
   assign next_inversion = is_inv_on ? 1'b1
                         : is_inv_off ? 1'b0
                         : inversion;
   assign next_disp_on = is_disp_on ? 1'b1
                       : is_disp_off ? 1'b0
                       : disp_on;
   assign next_gamma = (gamma_stb && gamma_ok) ? gamma_val : gamma_curve;

   // Forced pixel state: only pixel commands and mode commands touch it
   always_comb
   begin
      next_pix = pix;
      if (is_normal || is_partial)
      begin
         next_pix = DMCL_PIX_FRAME;
      end
      else if (is_black)
      begin
         next_pix = DMCL_PIX_BLACK;
      end
      else if (is_white)
      begin
         next_pix = DMCL_PIX_WHITE;
      end
   end

   assign any_change = (next_partial != partial) || (next_inversion != inversion)
                       || (next_pix != pix) || (next_gamma != gamma_curve)
                       || (next_disp_on != disp_on);

   // Software reset is applied synchronously to the same defaults
   always_ff @(posedge clk_i or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         partial <= DMCL_PARTIAL_RESET;
         inversion <= DMCL_INV_RESET;
         pix <= DMCL_PIX_RESET;
         gamma_curve <= DMCL_GAMMA_RESET;
         disp_on <= DMCL_DISP_ON_RESET;
      end
      else if (sw_reset_i)
      begin
         partial <= DMCL_PARTIAL_RESET;
         inversion <= DMCL_INV_RESET;
         pix <= DMCL_PIX_RESET;
         gamma_curve <= DMCL_GAMMA_RESET;
         disp_on <= DMCL_DISP_ON_RESET;
      end
      else
      begin
         partial <= next_partial;
         inversion <= next_inversion;
         pix <= next_pix;
         gamma_curve <= next_gamma;
         disp_on <= next_disp_on;
      end
   end

   // Panel-facing view; registered so a mode swap lands on one edge
   always_ff @(posedge clk_i or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         partial_mode_o <= 1'b0;
         inversion_o <= 1'b0;
         all_black_o <= 1'b0;
         all_white_o <= 1'b0;
         gamma_curve_select_o <= DMCL_GAMMA_RESET;
         display_on_o <= 1'b0;
         panel_blank_o <= 1'b1;
         panel_black_o <= 1'b0;
         panel_white_o <= 1'b0;
         panel_invert_o <= 1'b0;
         mode_change_o <= 1'b0;
      end
      else
      begin
         partial_mode_o <= partial;
         inversion_o <= inversion;
         all_black_o <= (pix == DMCL_PIX_BLACK);
         all_white_o <= (pix == DMCL_PIX_WHITE);
         gamma_curve_select_o <= gamma_curve;
         display_on_o <= disp_on;
         // Forced modes override display-off, but only in sleep-out
         panel_black_o <= sleep_out_i && (pix == DMCL_PIX_BLACK);
         panel_white_o <= sleep_out_i && (pix == DMCL_PIX_WHITE);
         panel_blank_o <= !disp_on || !sleep_out_i;
         panel_invert_o <= inversion;
         mode_change_o <= any_change && !sw_reset_i;
      end
   end
endmodule : dmcl_mode_ctrl

//--- tb/dmcl_host_model.sv
/*
 Host command source: issues command and parameter strobes.
 Assumes every task is entered at a falling clock edge.
*/
`timescale 1ns/1ps
module dmcl_host_model (
   input wire logic clk_i,
   output logic cmd_valid_o,
   output logic cmd_long_o,
   output logic [15:0] cmd_word_o,
   output logic param_valid_o,
   output logic [15:0] param_word_o
);
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_long_o = 1'b0;
      cmd_word_o = 16'h0000;
      param_valid_o = 1'b0;
      param_word_o = 16'h0000;
   end

   // Released words show the inverse so stale data never looks valid
   task automatic send_cmd(input logic [7:0] code, input logic lng);
      cmd_long_o = lng;
      cmd_word_o = lng ? {code, 8'h00} : {8'h00, code};
      cmd_valid_o = 1'b1;
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
      cmd_word_o = ~cmd_word_o;
      // One idle cycle so a following call never re-raises the strobe in the same step
      @(negedge clk_i);
   endtask : send_cmd

   task automatic send_param(input logic [7:0] val);
      param_word_o = {8'h00, val};
      param_valid_o = 1'b1;
      @(negedge clk_i);
      param_valid_o = 1'b0;
      param_word_o = ~param_word_o;
      @(negedge clk_i);
   endtask : send_param
endmodule : dmcl_host_model

//--- tb/dmcl_mode_ctrl_props.sv
/*
 Port assertions for the display-mode controller.
 Assumes no software reset lands within three cycles of a command.
*/
`timescale 1ns/1ps
module dmcl_mode_ctrl_props (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_long_i,
   input wire logic [15:0] cmd_word_i,
   input wire logic partial_mode_o,
   input wire logic inversion_o,
   input wire logic all_black_o,
   input wire logic all_white_o,
   input wire logic [7:0] gamma_curve_select_o,
   input wire logic display_on_o,
   input wire logic panel_blank_o,
   input wire logic panel_invert_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   wire logic lng = cmd_valid_i && cmd_long_i;
   wire logic sht = cmd_valid_i && !cmd_long_i;
   wire logic inv_cmd = (lng && cmd_word_i == 16'h2100) || (sht && cmd_word_i == 16'h0021);

   inv_on_a: assert property (lng && cmd_word_i == 16'h2100 |-> ##3 inversion_o)
      else $error("inversion not entered");
   normal_mode_a: assert property (sht && cmd_word_i == 16'h0013 |-> ##3 !partial_mode_o)
      else $error("partial mode not left");
   partial_on_a: assert property (sht && cmd_word_i == 16'h0012 |->
      ##3 partial_mode_o && !all_black_o && !all_white_o) else $error("partial entry wrong");
   all_black_a: assert property (lng && cmd_word_i == 16'h2200 |->
      ##3 all_black_o && !all_white_o) else $error("black mode wrong");
   all_white_a: assert property (sht && cmd_word_i == 16'h0023 |-> ##3 all_white_o)
      else $error("white mode not entered");
   disp_off_a: assert property (lng && cmd_word_i == 16'h2800 |->
      ##3 !display_on_o && panel_blank_o) else $error("display not off");
   invert_link_a: assert property (panel_invert_o == inversion_o)
      else $error("panel inversion differs");
   gamma_legal_a: assert property ($changed(gamma_curve_select_o) |->
      gamma_curve_select_o inside {8'h01, 8'h02, 8'h04, 8'h08}) else $error("gamma illegal");
   forced_excl_a: assert property (!(all_black_o && all_white_o))
      else $error("black and white both set");
   inv_cause_a: assert property ($rose(inversion_o) |-> $past(inv_cmd, 3))
      else $error("inversion rose without command");
endmodule : dmcl_mode_ctrl_props

bind dmcl_mode_ctrl dmcl_mode_ctrl_props u_props (.*);

//--- tb/display_mode_command_logic_test.sv
/*
 Self-checking bench for the display-mode controller.
 Assumes the host model drives at falling edges; outputs land 3 edges on.
*/
`timescale 1ns/1ps
module display_mode_command_logic_test;
   import dmcl_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic sw_reset_i = 1'b0;
   logic sleep_out_i = 1'b1;
   logic cmd_valid_i, cmd_long_i, param_valid_i;
   logic [15:0] cmd_word_i, param_word_i;
   logic partial_mode_o, inversion_o, all_black_o, all_white_o, display_on_o;
   logic panel_blank_o, panel_black_o, panel_white_o, panel_invert_o, mode_change_o;
   logic [7:0] gamma_curve_select_o;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int change_seen = 0;
   int pre = 0;
   logic [4:0] prev_exp = 5'h00;
   // Code, long bit 5, expected {partial, inversion, black, white, display}
   logic [15:0] rows [19] = '{16'h1210, 16'h1230, 16'h1320, 16'h1300, 16'h2128, 16'h2108,
      16'h230A, 16'h232A, 16'h222C, 16'h220C, 16'h292D, 16'h290D, 16'h1219, 16'h2011,
      16'h2031, 16'h2830, 16'h2810, 16'h2312, 16'h1300};

   always #12.5 clk_i = ~clk_i;

   dmcl_host_model u_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_long_o(cmd_long_i),
      .cmd_word_o(cmd_word_i), .param_valid_o(param_valid_i), .param_word_o(param_word_i));
   dmcl_mode_ctrl u_dut (.*);

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic settle;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask : settle

   // Panel view assumes sleep-out
   task automatic chk_modes(input logic [4:0] e);
      chk("modes", {3'h0, e}, {3'h0, partial_mode_o, inversion_o, all_black_o, all_white_o,
         display_on_o});
      chk("panel", {4'h0, !e[0], e[2], e[1], e[3]}, {4'h0, panel_blank_o, panel_black_o,
         panel_white_o, panel_invert_o});
   endtask : chk_modes

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   // Pulse is counted mid-cycle, away from the edge that launches it
   always @(negedge clk_i)
   begin
      if (mode_change_o === 1'b1)
         change_seen++;
   end

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         final_report();
      end
   end

   initial
   begin
      repeat (10) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk_modes(5'h00);
      chk("gamma", DMCL_GAMMA_CURVE1, gamma_curve_select_o);
      $display("reset defaults done");
      foreach (rows[k])
      begin
         pre = change_seen;
         u_host.send_cmd(rows[k][15:8], rows[k][5]);
         settle();
         chk_modes(rows[k][4:0]);
         chk("change", {7'h00, rows[k][4:0] != prev_exp}, 8'(change_seen - pre));
         prev_exp = rows[k][4:0];
      end
      $display("command table done");
      pre = change_seen;
      u_host.send_cmd(DMCL_CMD_GAMMA, 1'b0);
      u_host.send_param(8'h04);
      settle();
      chk("gamma", 8'h04, gamma_curve_select_o);
      chk("change", 8'h01, 8'(change_seen - pre));
      pre = change_seen;
      u_host.send_cmd(DMCL_CMD_GAMMA, 1'b1);
      u_host.send_param(8'h03);
      settle();
      chk("gamma", 8'h04, gamma_curve_select_o);
      chk("change", 8'h00, 8'(change_seen - pre));
      $display("gamma done");
      u_host.send_cmd(DMCL_CMD_INV_ON, 1'b1);
      u_host.send_param(8'h00);
      u_host.send_cmd(DMCL_CMD_ALL_BLACK, 1'b0);
      u_host.send_cmd(DMCL_CMD_DISP_ON, 1'b0);
      sleep_out_i = 1'b0;
      settle();
      chk("modes", 8'h0D, {3'h0, partial_mode_o, inversion_o, all_black_o, all_white_o,
         display_on_o});
      chk("panel", 8'h09, {4'h0, panel_blank_o, panel_black_o, panel_white_o,
         panel_invert_o});
      sleep_out_i = 1'b1;
      settle();
      pre = change_seen;
      sw_reset_i = 1'b1;
      @(negedge clk_i);
      sw_reset_i = 1'b0;
      settle();
      chk_modes(5'h00);
      chk("gamma", DMCL_GAMMA_RESET, gamma_curve_select_o);
      chk("change", 8'h00, 8'(change_seen - pre));
      $display("sleep and software reset done");
      u_host.send_cmd(DMCL_CMD_INV_ON, 1'b1);
      u_host.send_cmd(DMCL_CMD_PARTIAL_ON, 1'b0);
      settle();
      reset_n_i = 1'b0;
      @(negedge clk_i);
      chk_modes(5'h00);
      reset_n_i = 1'b1;
      // Synchronised release needs two edges before the first command
      repeat (3) @(negedge clk_i);
      u_host.send_cmd(DMCL_CMD_INV_ON, 1'b1);
      settle();
      chk_modes(5'h08);
      $display("hardware reset done");
      final_report();
   end
endmodule : display_mode_command_logic_test
